// ===== hdl/qbp_mc_timer.sv
// Purpose: divides the oscillator clock into six states of two phases
// Assumes: sys_rst synchronous, active high
// Notes: first cycle after reset release is S1P1
`timescale 1ns/1ns
module qbp_mc_timer (
  input wire logic core_clk,
  input wire logic sys_rst,
  qbp_tim_if.gen tim
);

  logic [3:0] ph_cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // phase counter, wraps after S6P2
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ph_cnt_r <= qbp_pkg::PH_CNT_RST;
    end else if (ph_cnt_r == qbp_pkg::PH_LAST) begin
      ph_cnt_r <= qbp_pkg::PH_CNT_RST;
    end else begin
      ph_cnt_r <= ph_cnt_r + 4'h1;
    end
  end

  // strobe decode, even counts are phase 1
  assign tim.phase1 = ~ph_cnt_r[0];
  assign tim.s1p1 = (ph_cnt_r == qbp_pkg::PH_S1P1);
  assign tim.s1p2 = (ph_cnt_r == qbp_pkg::PH_S1P2);
  assign tim.s5p1 = (ph_cnt_r == qbp_pkg::PH_S5P1);
  assign tim.s5p2 = (ph_cnt_r == qbp_pkg::PH_S5P2);
  assign tim.s6p2 = (ph_cnt_r == qbp_pkg::PH_S6P2);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_cycle_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    tim.s6p2 |=> tim.s1p1 ##11 tim.s6p2) else $error("machine cycle is not twelve phases");

endmodule // qbp_mc_timer

// ===== hdl/qbp_pkg.sv
// Purpose: shared constants and types for the quasi-bidirectional port bit driver
// Assumes: one core_clk period equals one oscillator period (one phase)
// Notes: machine cycle is S1P1 .. S6P2, twelve phases, counted 0 to 11
package qbp_pkg;

  // machine-cycle timing
  localparam int unsigned PHASES_PER_CYCLE = 12;
  localparam logic [3:0] PH_CNT_RST = 4'h0;
  localparam logic [3:0] PH_LAST = 4'hB;
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S1P2 = 4'h1;
  localparam logic [3:0] PH_S5P1 = 4'h8;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P2 = 4'hB;

  // boost pullup lasts two oscillator periods
  localparam logic [1:0] BOOST_PHASES = 2'h2;

  // values after reset
  localparam logic LATCH_RST = 1'b1;
  localparam logic OUT_BUF_RST = 1'b1;
  localparam logic SAMPLE_RST = 1'b1;

  // driver states, gray coded along input_low -> input_high -> forced_high
  typedef enum logic [1:0] {
    input_low_state = 2'h0,
    input_high_state = 2'h1,
    forced_high_state = 2'h3,
    output_low_state = 2'h2
  } qbp_drv_state_e;

  // steady high is electrically the same state as input high
  localparam qbp_drv_state_e steady_high_state = input_high_state;

endpackage

// ===== hdl/qbp_port_bit.sv
// Purpose: driver enables, latch timing and pin sampling for one quasi-bidirectional bit
// Assumes: latch_wr from the CPU on core_clk; pin_level and pin_high_sense are asynchronous
// Notes: enables are registered; a write is applied at the next S6P2
//
// Behaviour
// - strong pulldown is on only while the latch holds zero
// - a zero-to-one latch write gives boost pullup during S1P1 and S1P2
// - weak pullup stays on whenever the latch holds one
// - holding pullup is on only while the pin senses high or the boost pullup is on (forced high)
// - four driver states: input low, input/steady high, forced high, output low
// - writing one over one starts no boost and changes nothing
// - reset sets the latch to one, pin starts in input low state
// - a latch write takes effect at S6P2 of the cycle
// - output buffer follows the latch in phase 1, holds in phase 2
// - pin sampled once per machine cycle in state 5, phase selectable
// - edge flagged when the sample differs from the previous cycle's
// - machine cycle is twelve oscillator periods, six states of two phases
`timescale 1ns/1ns
module qbp_port_bit (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic latch_wr,
  input wire logic latch_wr_data,
  input wire logic sample_in_phase2,
  input wire logic pin_level,
  input wire logic pin_high_sense,
  output logic latch_rd_data,
  output logic pin_rd_data,
  output logic pin_edge,
  output logic pin_fall,
  output logic strong_pulldown,
  output logic boost_pullup,
  output logic weak_pullup,
  output logic holding_pullup,
  output qbp_pkg::qbp_drv_state_e driver_state
);

  qbp_tim_if tim ();

  logic latch_r;
  logic latch_nxt;
  logic wr_pend_r;
  logic wr_data_r;
  logic out_buf_r;
  logic out_buf_nxt;
  logic [1:0] boost_cnt_r;
  logic [1:0] boost_cnt_nxt;
  logic sense_s1_r;
  logic sense_s2_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic sample_r;
  logic edge_r;
  logic fall_r;
  logic sample_now;
  qbp_pkg::qbp_drv_state_e state_r;
  qbp_pkg::qbp_drv_state_e state_nxt;

  // map a driver state to its four enables {pulldown, boost, weak, holding}
  function automatic logic [3:0] drv_enables(input qbp_pkg::qbp_drv_state_e st);
    unique case (st)
      qbp_pkg::input_low_state: drv_enables = 4'h2;
      qbp_pkg::input_high_state: drv_enables = 4'h3;
      qbp_pkg::forced_high_state: drv_enables = 4'h7;
      qbp_pkg::output_low_state: drv_enables = 4'h8;
    endcase
  endfunction

  qbp_mc_timer u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tim(tim)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write request held until S6P2 so a write in any phase is not lost
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_data_r <= qbp_pkg::LATCH_RST;
    end else if (latch_wr && !tim.s6p2) begin
      wr_pend_r <= 1'b1;
      wr_data_r <= latch_wr_data;
    end else if (tim.s6p2) begin
      wr_pend_r <= 1'b0;
    end
  end

  // new latch value lands only at S6P2; a same-cycle write beats the held one
  always_comb begin
    latch_nxt = latch_r;
    if (tim.s6p2) begin
      if (latch_wr) begin
        latch_nxt = latch_wr_data;
      end else if (wr_pend_r) begin
        latch_nxt = wr_data_r;
      end
    end
  end

  // latch is one after reset so the pin comes up as an input
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latch_r <= qbp_pkg::LATCH_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer loads at the edge into a phase-1 period, holds through phase 2
  assign out_buf_nxt = tim.phase1 ? out_buf_r : latch_nxt;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_buf_r <= qbp_pkg::OUT_BUF_RST;
    end else begin
      out_buf_r <= out_buf_nxt;
    end
  end

  // boost armed only by a real zero-to-one latch change, old vs new value
  always_comb begin
    boost_cnt_nxt = (boost_cnt_r != 2'h0) ? boost_cnt_r - 2'h1 : 2'h0;
    if (tim.s6p2 && !latch_r && latch_nxt) begin
      boost_cnt_nxt = qbp_pkg::BOOST_PHASES;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      boost_cnt_r <= 2'h0;
    end else begin
      boost_cnt_r <= boost_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the asynchronous pin signals
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sense_s1_r <= 1'b0;
      sense_s2_r <= 1'b0;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      sense_s1_r <= pin_high_sense;
      sense_s2_r <= sense_s1_r;
      pin_s1_r <= pin_level;
      pin_s2_r <= pin_s1_r;
    end
  end

  // driver state follows next buffer value; pulldown case overrides all pullups
  always_comb begin
    if (!out_buf_nxt) begin
      state_nxt = qbp_pkg::output_low_state;
    end else if (boost_cnt_nxt != 2'h0) begin
      state_nxt = qbp_pkg::forced_high_state;
    end else if (sense_s2_r) begin
      state_nxt = qbp_pkg::steady_high_state;
    end else begin
      state_nxt = qbp_pkg::input_low_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= qbp_pkg::input_low_state;
    end else begin
      state_r <= state_nxt;
    end
  end

  // enables decoded from the state register, glitch free at the pins
  assign {strong_pulldown, boost_pullup, weak_pullup, holding_pullup} =
    drv_enables(state_r);
  assign driver_state = state_r;
  assign latch_rd_data = latch_r;

  ////////////////////////////////////////////////////////////////////////////
  // one sample per machine cycle in state 5; phase picked by alternate function
  assign sample_now = sample_in_phase2 ? tim.s5p2 : tim.s5p1;

  // pulses shorter than a machine cycle can slip between samples
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sample_r <= qbp_pkg::SAMPLE_RST;
      edge_r <= 1'b0;
      fall_r <= 1'b0;
    end else if (sample_now) begin
      sample_r <= pin_s2_r;
      edge_r <= (pin_s2_r != sample_r);
      fall_r <= sample_r && !pin_s2_r;
    end else begin
      edge_r <= 1'b0;
      fall_r <= 1'b0;
    end
  end

  assign pin_rd_data = sample_r;
  assign pin_edge = edge_r;
  assign pin_fall = fall_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence boost_window;
    tim.s1p1 && boost_pullup ##1 tim.s1p2 && boost_pullup ##1 !boost_pullup;
  endsequence

  chk_pulldown_latch: assert property ($rose(strong_pulldown) |-> !latch_r && $past(tim.s6p2))
    else $error("pulldown enabled without a zero in the latch");
  chk_boost_len: assert property ($rose(boost_pullup) |-> boost_window)
    else $error("boost pullup not exactly S1P1 and S1P2");
  chk_boost_cause: assert property ($rose(boost_pullup) |-> latch_r && !$past(latch_r))
    else $error("boost without a zero to one latch change");
  chk_weak_latch: assert property (tim.s1p1 && latch_r |-> weak_pullup && !strong_pulldown)
    else $error("weak pullup off while latch holds one");
  // forced high turns on all three pullups, so sense only governs the steady states
  chk_hold_sense: assert property (holding_pullup && !boost_pullup |->
    $past(sense_s2_r) && weak_pullup)
    else $error("holding pullup on while pin not sensed high");
  chk_low_alone: assert property (strong_pulldown |-> !(boost_pullup || weak_pullup || holding_pullup))
    else $error("pullup fighting the pulldown");
  chk_latch_time: assert property (latch_r != $past(latch_r) |-> $past(tim.s6p2))
    else $error("latch changed outside S6P2");
  chk_pin_time: assert property (out_buf_r != $past(out_buf_r) |-> tim.s1p1)
    else $error("driver value changed outside S1P1");
  chk_sample_time: assert property (pin_rd_data != $past(pin_rd_data) |-> $past(tim.s5p1 || tim.s5p2))
    else $error("pin sampled outside state 5");
  chk_edge_flag: assert property (pin_edge |-> pin_rd_data != $past(pin_rd_data))
    else $error("edge flagged without a sample change");

endmodule // qbp_port_bit

// ===== hdl/qbp_tim_if.sv
// Purpose: machine-cycle timing strobes passed from the timer to the driver logic
// Assumes: all strobes are one-phase pulses on core_clk
// Notes: phase1 is high in every phase-1 period
`timescale 1ns/1ns
interface qbp_tim_if;
  logic phase1;
  logic s1p1;
  logic s1p2;
  logic s5p1;
  logic s5p2;
  logic s6p2;

  modport gen (output phase1, output s1p1, output s1p2, output s5p1, output s5p2, output s6p2);
  modport use_side (input phase1, input s1p1, input s1p2, input s5p1, input s5p2, input s6p2);
endinterface

// ===== testbench/qbp_pin_model.sv
// Purpose: behavioural pin and outside circuit for one quasi-bidirectional bit
// Assumes: the outside circuit can only pull the pin low or let it go
// Notes: sense follows the resolved pin level; trip point taken as logic high
`timescale 1ns/1ns
module qbp_pin_model (
  input wire logic strong_pulldown,
  input wire logic boost_pullup,
  input wire logic weak_pullup,
  input wire logic holding_pullup,
  input wire logic ext_low,
  output logic pin_level,
  output logic pin_high_sense
);
  ////////////////////////////////////////////////////////////////////////////////
  // wire resolution: any low driver wins over the pullups
  always_comb begin
    if (strong_pulldown || ext_low) begin
      pin_level = 1'b0;
    end else begin
      pin_level = weak_pullup | holding_pullup | boost_pullup;
    end
  end
  // sense above trip point, no analog hysteresis modelled
  assign pin_high_sense = pin_level;
endmodule // qbp_pin_model

// ===== testbench/quasi_bidir_port_driver_ctrl_test.sv
// Purpose: self-checking bench for the port bit driver
// Assumes: first cycle after reset release is S1P1
// Notes: bench tracks the phase itself from reset release
`timescale 1ns/1ns
module quasi_bidir_port_driver_ctrl_test;
  typedef struct {
    logic d;
    logic ext;
    logic [3:0] en;
    qbp_pkg::qbp_drv_state_e st;
  } qbp_row_s;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic latch_wr = 1'b0;
  logic latch_wr_data = 1'b1;
  logic sample_in_phase2 = 1'b0;
  logic ext_low = 1'b0;
  logic pin_level, pin_high_sense, latch_rd_data, pin_rd_data, pin_edge, pin_fall;
  logic strong_pulldown, boost_pullup, weak_pullup, holding_pullup;
  qbp_pkg::qbp_drv_state_e driver_state;
  logic [3:0] en;
  logic [3:0] ph = 4'h0;
  int err_total = 0;
  int compares = 0;
  qbp_row_s rows [5];
  ////////////////////////////////////////////////////////////////////////////////
  always #4 core_clk = ~core_clk;
  // phase of the cycle that begins at this edge
  always @(posedge core_clk) ph <= (sys_rst || ph == 4'hB) ? 4'h0 : ph + 4'h1;
  assign en = {strong_pulldown, boost_pullup, weak_pullup, holding_pullup};
  qbp_port_bit dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .latch_wr(latch_wr),
    .latch_wr_data(latch_wr_data), .sample_in_phase2(sample_in_phase2),
    .pin_level(pin_level), .pin_high_sense(pin_high_sense),
    .latch_rd_data(latch_rd_data), .pin_rd_data(pin_rd_data), .pin_edge(pin_edge),
    .pin_fall(pin_fall), .strong_pulldown(strong_pulldown), .boost_pullup(boost_pullup),
    .weak_pullup(weak_pullup), .holding_pullup(holding_pullup),
    .driver_state(driver_state)
  );
  qbp_pin_model pin_u (
    .strong_pulldown(strong_pulldown), .boost_pullup(boost_pullup),
    .weak_pullup(weak_pullup), .holding_pullup(holding_pullup), .ext_low(ext_low),
    .pin_level(pin_level), .pin_high_sense(pin_high_sense)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // one compare, mismatch reported at once
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // land just after the edge that opens phase p
  task automatic wait_ph(input logic [3:0] p);
    do begin
      @(posedge core_clk);
      #1;
    end while (ph != p);
  endtask
  // write in S1P1; old value must survive to S6P2, new one seen in S1P1
  task automatic do_write(input logic d);
    logic old;
    old = latch_rd_data;
    wait_ph(4'h0);
    latch_wr = 1'b1;
    latch_wr_data = d;
    @(posedge core_clk);
    #1;
    latch_wr = 1'b0;
    wait_ph(4'hB);
    check({3'h0, latch_rd_data}, {3'h0, old});
    wait_ph(4'h0);
    check({3'h0, latch_rd_data}, {3'h0, d});
  endtask
  task automatic end_of_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, full run needs well under 2000 cycles
  initial begin
    #20000;
    err_total++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{1'b1, 1'b0, 4'h3, qbp_pkg::steady_high_state};
    rows[1] = '{1'b0, 1'b0, 4'h8, qbp_pkg::output_low_state};
    rows[2] = '{1'b1, 1'b0, 4'h3, qbp_pkg::input_high_state};
    rows[3] = '{1'b1, 1'b1, 4'h2, qbp_pkg::input_low_state};
    rows[4] = '{1'b1, 1'b0, 4'h3, qbp_pkg::input_high_state};
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    // latch one, only weak pullup while sense is still low
    check({latch_rd_data, pin_rd_data, pin_edge, pin_fall}, 4'hC);
    check(en, 4'h2);
    check({2'h0, driver_state}, {2'h0, qbp_pkg::input_low_state});
    // table: level settles mid machine cycle; outside low only while latch is one
    foreach (rows[i]) begin
      ext_low = rows[i].ext;
      do_write(rows[i].d);
      wait_ph(4'h6);
      check(en, rows[i].en);
      check({2'h0, driver_state}, {2'h0, rows[i].st});
    end
    // zero then one gives boost for exactly S1P1 and S1P2
    do_write(1'b0);
    do_write(1'b1);
    check({1'b0, boost_pullup, strong_pulldown, weak_pullup}, 4'h5);
    check({2'h0, driver_state}, {2'h0, qbp_pkg::forced_high_state});
    @(posedge core_clk);
    #1;
    check({3'h0, boost_pullup}, 4'h1);
    @(posedge core_clk);
    #1;
    check({3'h0, boost_pullup}, 4'h0);
    // one over one: no boost anywhere in the machine cycle
    do_write(1'b1);
    repeat (12) begin
      check(en, 4'h3);
      @(posedge core_clk);
      #1;
    end
    // state-5 sampling in both phases, fall then rise
    for (int s = 0; s < 2; s++) begin
      sample_in_phase2 = s[0];
      wait_ph(4'h0);
      ext_low = 1'b1;
      wait_ph(4'h9 + s[3:0]);
      check({1'b0, pin_rd_data, pin_edge, pin_fall}, 4'h3);
      @(posedge core_clk);
      #1;
      check({2'h0, pin_edge, pin_fall}, 4'h0);
      wait_ph(4'h0);
      ext_low = 1'b0;
      wait_ph(4'h8 + s[3:0]);
      check({1'b0, pin_rd_data, pin_edge, pin_fall}, 4'h0);
      @(posedge core_clk);
      #1;
      check({1'b0, pin_rd_data, pin_edge, pin_fall}, 4'h6);
    end
    end_of_test();
  end
endmodule // quasi_bidir_port_driver_ctrl_test
